/* hdl/prf_frame.sv */
`timescale 1ns/1ns
module prf_frame (
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic                         ic_win_sel,
    output logic      [1:0][7:0]         cfg_out,
    output logic      [1:0][7:0]         func_enable,
    output logic      [1:0][7:0]         cmd_pulse,
    input  wire logic [1:0][5:0]         func_status,
    output logic      [1:0]              irq,
    input  wire prf_pkg::prf_chan_req_t  chan_req [4],
    output prf_pkg::prf_chan_out_t       chan_out [4]
);
    import prf_pkg::*;

    // Bus phase decode
    logic        setup_ph;
    logic        wr_ph;
    logic [13:0] off;
    logic [1:0]  unit_hit;

    assign setup_ph = psel & ~penable;
    assign wr_ph    = psel & penable & pwrite;
    assign off      = {paddr[13:2], 2'b00};

    assign ic_win_sel = psel & (paddr[31:PRF_IC_BITS] == PRF_IC_PAGE);

    // Zero-wait slave; internal peripherals never abort
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    logic [31:0] ptr [PRF_NUM_CH];
    logic [15:0] cnt [PRF_NUM_CH];
    logic [31:0] unit_rd [PRF_NUM_UNITS];

    genvar u;
    generate
        for (u = 0; u < PRF_NUM_UNITS; u++) begin : g_unit
            logic       hit;
            logic       wr_cmd;
            logic       wr_cfg;
            logic       wr_fen;
            logic       wr_fdis;
            logic       wr_ien;
            logic       wr_idis;
            logic [7:0] wbits;
            logic [7:0] cfg;
            logic [7:0] fen;
            logic [7:0] mask;
            logic [7:0] stat;
            logic [7:0] next_fen;
            logic [7:0] next_mask;
            logic       next_irq;

            assign hit = paddr[31:PRF_WIN_BITS] == PRF_UNIT_PAGE[u];
            assign unit_hit[u] = hit;

            assign wbits = pwdata[7:0];

            assign wr_cmd  = wr_ph & hit & (off == PRF_OFF_CMD);
            assign wr_cfg  = wr_ph & hit & (off == PRF_OFF_CFG);
            assign wr_fen  = wr_ph & hit & (off == PRF_OFF_FEN);
            assign wr_fdis = wr_ph & hit & (off == PRF_OFF_FDIS);
            assign wr_ien  = wr_ph & hit & (off == PRF_OFF_IEN);
            assign wr_idis = wr_ph & hit & (off == PRF_OFF_IDIS);

            assign stat = {func_status[u],
                           ~chan_out[2*u+1].active,
                           ~chan_out[2*u].active};

            assign next_fen = wr_fen  ? (fen | wbits)
                            : wr_fdis ? (fen & ~wbits) : fen;
            assign next_mask = wr_ien  ? (mask | wbits)
                             : wr_idis ? (mask & ~wbits) : mask;
            assign next_irq = |(stat & mask);

            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cfg          <= PRF_CFG_RST;
                    fen          <= PRF_BITS_RST;
                    mask         <= PRF_BITS_RST;
                    cmd_pulse[u] <= PRF_BITS_RST;
                    irq[u]       <= 1'b0;
                end else begin
                    if (wr_cfg) begin
                        cfg <= wbits;
                    end
                    fen    <= next_fen;
                    mask   <= next_mask;
                    irq[u] <= next_irq;
                    cmd_pulse[u] <= wr_cmd ? wbits : PRF_BITS_RST;
                end
            end

            assign cfg_out[u]     = cfg;
            assign func_enable[u] = fen;

            // Read mux; command and set/clear regs read zero
            // unused bits read zero
            assign unit_rd[u] =
                (off == PRF_OFF_CFG)   ? {24'h000000, cfg}  :
                (off == PRF_OFF_FSTAT) ? {24'h000000, fen}  :
                (off == PRF_OFF_STAT)  ? {24'h000000, stat} :
                (off == PRF_OFF_IMASK) ? {24'h000000, mask} :
                (off == PRF_OFF_RXPTR) ? ptr[2*u]           :
                (off == PRF_OFF_RXCNT) ? {16'h0000, cnt[2*u]} :
                (off == PRF_OFF_TXPTR) ? ptr[2*u+1]         :
                (off == PRF_OFF_TXCNT) ? {16'h0000, cnt[2*u+1]} :
                32'h0000_0000;
        end
    endgenerate

    // even channel rx, odd tx of unit c/2
    genvar c;
    generate
        for (c = 0; c < PRF_NUM_CH; c++) begin : g_chan
            localparam int          UN  = c / 2;
            localparam logic [13:0] PO  = (c % 2 == 0) ? PRF_OFF_RXPTR
                                                       : PRF_OFF_TXPTR;
            localparam logic [13:0] CO  = (c % 2 == 0) ? PRF_OFF_RXCNT
                                                       : PRF_OFF_TXCNT;
            logic        wr_ptr;
            logic        wr_cnt;
            logic        adv;
            logic [31:0] next_ptr;
            logic [15:0] next_cnt;

            assign wr_ptr = wr_ph & unit_hit[UN] & (off == PO);
            assign wr_cnt = wr_ph & unit_hit[UN] & (off == CO);
            // Done ignored once count is zero
            assign adv    = chan_req[c].done & (cnt[c] != PRF_CNT_RST);

            // advance pointer, decrement count
            // Software write wins so a reprogram is never lost
            assign next_ptr = wr_ptr ? pwdata
                            : adv ? ptr[c] + prf_step(chan_req[c].size)
                            : ptr[c];
            assign next_cnt = wr_cnt ? pwdata[15:0]
                            : adv ? cnt[c] - 16'h0001
                            : cnt[c];

            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ptr[c] <= PRF_PTR_RST;
                    cnt[c] <= PRF_CNT_RST;
                end else begin
                    ptr[c] <= next_ptr;
                    cnt[c] <= next_cnt;
                end
            end

            assign chan_out[c].active = cnt[c] != PRF_CNT_RST;
            assign chan_out[c].addr   = ptr[c];
        end
    endgenerate

    // Read data captured in setup, valid in access phase
    logic [31:0] next_rd;

    assign next_rd = !setup_ph    ? prdata
                   : unit_hit[0]  ? unit_rd[0]
                   : unit_hit[1]  ? unit_rd[1]
                   : PRF_RD_RST;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= PRF_RD_RST;
        end else begin
            prdata <= next_rd;
        end
    end

endmodule : prf_frame

/* hdl/prf_pkg.sv */
package prf_pkg;

    // Bus and layout
    localparam int          PRF_DATA_W     = 32;
    localparam int          PRF_NUM_UNITS  = 2;
    localparam int          PRF_NUM_CH     = 4;
    localparam int          PRF_WIN_BITS   = 14;
    localparam int          PRF_IC_BITS    = 12;
    localparam int          PRF_CFG_W      = 8;
    localparam int          PRF_BITS_W     = 8;
    localparam int          PRF_FUNC_W     = 6;
    localparam int          PRF_CNT_W      = 16;

    // Window pages: base address shifted right by the window size
    localparam logic [PRF_NUM_UNITS-1:0][17:0] PRF_UNIT_PAGE =
        {18'h3FFF1, 18'h3FFF0};
    localparam logic [19:0] PRF_IC_PAGE    = 20'hFFFFF;

    // Byte offsets inside a unit window
    localparam logic [13:0] PRF_OFF_CMD    = 14'h0000;
    localparam logic [13:0] PRF_OFF_CFG    = 14'h0004;
    localparam logic [13:0] PRF_OFF_FEN    = 14'h0008;
    localparam logic [13:0] PRF_OFF_FDIS   = 14'h000C;
    localparam logic [13:0] PRF_OFF_FSTAT  = 14'h0010;
    localparam logic [13:0] PRF_OFF_STAT   = 14'h0014;
    localparam logic [13:0] PRF_OFF_IEN    = 14'h0018;
    localparam logic [13:0] PRF_OFF_IDIS   = 14'h001C;
    localparam logic [13:0] PRF_OFF_IMASK  = 14'h0020;
    localparam logic [13:0] PRF_OFF_RXPTR  = 14'h0030;
    localparam logic [13:0] PRF_OFF_RXCNT  = 14'h0034;
    localparam logic [13:0] PRF_OFF_TXPTR  = 14'h0038;
    localparam logic [13:0] PRF_OFF_TXCNT  = 14'h003C;

    // Status field positions
    localparam int          PRF_STAT_RX_END = 0;
    localparam int          PRF_STAT_TX_END = 1;
    localparam int          PRF_STAT_FUNC   = 2;

    // Reset values
    localparam logic [7:0]  PRF_CFG_RST    = 8'h00;
    localparam logic [7:0]  PRF_BITS_RST   = 8'h00;
    localparam logic [31:0] PRF_PTR_RST    = 32'h0000_0000;
    localparam logic [15:0] PRF_CNT_RST    = 16'h0000;
    localparam logic [31:0] PRF_RD_RST     = 32'h0000_0000;

    // Transfer size codes
    localparam logic [1:0]  PRF_SZ_BYTE    = 2'h0;
    localparam logic [1:0]  PRF_SZ_HALF    = 2'h1;

    typedef struct packed {
        logic        done;
        logic [1:0]  size;
    } prf_chan_req_t;

    typedef struct packed {
        logic        active;
        logic [31:0] addr;
    } prf_chan_out_t;

    function automatic logic [31:0] prf_step(input logic [1:0] sz);
        case (sz)
            PRF_SZ_BYTE: prf_step = 32'h0000_0001;
            PRF_SZ_HALF: prf_step = 32'h0000_0002;
            default:     prf_step = 32'h0000_0004;
        endcase
    endfunction : prf_step

endpackage : prf_pkg

/* tb/prf_core_model.sv */
`timescale 1ns/1ns
module prf_core_model (
    input  wire logic        core_clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata
);
    initial begin
        {psel, penable, pwrite} = 3'h0;
        {paddr, pwdata} = 64'h0;
    end
    task automatic xfer(input logic w, input logic [31:0] a, d, m,
                        output logic [31:0] q);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d & m;
        @(posedge core_clk);
        penable <= 1'h1;
        @(posedge core_clk);
        repeat (8) if (pready !== 1'h1) @(posedge core_clk);
        q = prdata;
        {psel, penable} <= 2'h0;
        // Released lines toggle so stale values never look valid
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : prf_core_model

/* tb/prf_frame_props.sv */
`timescale 1ns/1ns
module prf_frame_props
    import prf_pkg::*;
(
    input wire logic                   core_clk,
    input wire logic                   sys_rst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   ic_win_sel,
    input wire logic [1:0][7:0]        cfg_out,
    input wire logic [1:0][7:0]        func_enable,
    input wire logic [1:0][7:0]        cmd_pulse,
    input wire prf_pkg::prf_chan_req_t chan_req [4],
    input wire prf_pkg::prf_chan_out_t chan_out [4]
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire acc = psel && penable && pwrite;
    wire [31:0] step0 = chan_req[0].size == 2'h0 ? 32'h1 :
                        chan_req[0].size == 2'h1 ? 32'h2 : 32'h4;
    sequence s_wr(logic [13:0] o);
        acc && paddr[31:14] == PRF_UNIT_PAGE[0] && paddr[13:2] == o[13:2];
    endsequence
    // Setup of a read that misses every register
    sequence s_hole;
        psel && !penable && !pwrite && paddr[31:14] == PRF_UNIT_PAGE[0]
            && paddr[13:6] != 8'h00;
    endsequence
    chk_cmd_pulse: assert property (s_wr(PRF_OFF_CMD)
        |=> cmd_pulse[0] == $past(pwdata[7:0])) else $error("cmd pulse");
    chk_cmd_idle: assert property (!acc |=> cmd_pulse == 16'h0000)
        else $error("stray cmd pulse");
    chk_cfg_store: assert property (s_wr(PRF_OFF_CFG)
        |=> cfg_out[0] == $past(pwdata[7:0])) else $error("cfg store");
    chk_set_bits: assert property (s_wr(PRF_OFF_FEN) |=>
        func_enable[0] == ($past(func_enable[0]) | $past(pwdata[7:0])))
        else $error("set bits");
    chk_clr_bits: assert property (s_wr(PRF_OFF_FDIS) |=>
        func_enable[0] == ($past(func_enable[0]) & ~$past(pwdata[7:0])))
        else $error("clear bits");
    chk_hole_zero: assert property (s_hole |=> prdata == 32'h0)
        else $error("hole not zero");
    chk_ic_window: assert property (ic_win_sel ==
        (psel && paddr[31:12] == PRF_IC_PAGE)) else $error("ic window");
    chk_ptr_step: assert property (chan_req[0].done
        && chan_out[0].active && !acc |=> chan_out[0].addr ==
        $past(chan_out[0].addr) + $past(step0)) else $error("ptr step");
    chk_ptr_hold: assert property (!acc && !(chan_req[0].done
        && chan_out[0].active) |=> $stable(chan_out[0].addr))
        else $error("ptr moved");
endmodule : prf_frame_props

/* tb/prf_frame_tb.sv */
`timescale 1ns/1ns
module prf_frame_tb;
    import prf_pkg::*;
    localparam logic [13:0] OFFS [9] = '{PRF_OFF_CMD, PRF_OFF_CFG,
        PRF_OFF_FSTAT, PRF_OFF_IMASK, PRF_OFF_RXPTR, PRF_OFF_RXCNT,
        PRF_OFF_TXPTR, PRF_OFF_TXCNT, 14'h0040};
    logic            core_clk = 1'h0;
    logic            sys_rst = 1'h1;
    logic            psel, penable, pwrite, pready, pslverr, ic_win_sel;
    logic [31:0]     paddr, pwdata, prdata, q, e, p;
    logic [1:0][7:0] cfg_out, func_enable, cmd_pulse, cf, sh;
    logic [1:0][5:0] func_status = 12'h000;
    logic [1:0]      irq;
    logic [13:0]     o;
    prf_chan_req_t   chan_req [4] = '{default: 3'h0};
    prf_chan_out_t   chan_out [4];
    int              seed = 24;
    int              u;
    int              bad_count = 0;
    int              cmp_count = 0;
    always #5 core_clk = ~core_clk;
    prf_frame dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ic_win_sel, .cfg_out,
        .func_enable, .cmd_pulse, .func_status, .irq, .chan_req, .chan_out);
    prf_core_model core (.core_clk, .prdata, .pready, .psel, .penable,
        .pwrite, .paddr, .pwdata);
    task automatic chk(input logic [31:0] g, x, input string m);
        cmp_count++;
        if (g !== x) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    function automatic logic [31:0] ua(int n, logic [13:0] f);
        return {PRF_UNIT_PAGE[n], f};
    endfunction : ua
    function automatic logic [31:0] stp(logic [1:0] s);
        return s == 2'h0 ? 32'h1 : s == 2'h1 ? 32'h2 : 32'h4;
    endfunction : stp
    task automatic wr(input logic [31:0] a, d, m);
        core.xfer(1'h1, a, d, m, q);
    endtask : wr
    task automatic rd(input logic [31:0] a, x, input string m);
        core.xfer(1'h0, a, 32'h0, 32'h0, q);
        chk(q, x, m);
    endtask : rd
    task automatic wrap_up;
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    // Whole run needs about 600 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        {cf, sh} = 32'h0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'h0;
        func_status <= 12'($random(seed));
        wr(ua(0, 14'h0040), 32'hFF, 32'hFF);
        wr(32'hFFFFF004, 32'h0, 32'h0);
        for (int n = 0; n < 2; n++) begin
            foreach (OFFS[i]) rd(ua(n, OFFS[i]), 32'h0, "reset value");
            wr(ua(n, PRF_OFF_STAT), 32'($random(seed)), 32'hFF);
            rd(ua(n, PRF_OFF_STAT), {func_status[n], 2'h3}, "status");
        end
        for (int i = 0; i < 40; i++) begin
            e = $random(seed);
            u = e[8];
            wr(ua(u, {10'h0, e[10:9], e[12:11]}), e, 32'hFF);
            case (e[10:9])
                2'h1: cf[u] = e[7:0];
                2'h2: sh[u] = sh[u] | e[7:0];
                2'h3: sh[u] = sh[u] & ~e[7:0];
                default: ;
            endcase
            @(negedge core_clk);
            chk(cfg_out[u], cf[u], "config out");
            chk(func_enable[u], sh[u], "shadow out");
            rd(ua(u, PRF_OFF_FSTAT), sh[u], "shadow read");
            rd(ua(u, {10'h0, e[10:9], 2'h0}), e[10:9] == 2'h1 ?
                {24'h0, cf[u]} : 32'h0, "readback");
        end
        for (int c = 0; c < 4; c++) begin
            u = c / 2;
            o = c % 2 ? PRF_OFF_TXPTR : PRF_OFF_RXPTR;
            p = $random(seed);
            wr(ua(u, o), p, 32'hFFFFFFFF);
            rd(ua(u, o), p, "ptr read");
            chk(pready, 1'h1, "ready low");
            chk(pslverr, 1'h0, "slave error");
            wr(ua(u, o + 14'h4), 32'h3, 32'hFFFF);
            wr(ua(u, PRF_OFF_IEN), 32'h1 << c % 2, 32'hFF);
            @(negedge core_clk);
            chk(irq[u], 1'h0, "irq early");
            // Last pulse arrives with count zero and must be ignored
            for (int k = 0; k < 6; k++) begin
                @(posedge core_clk);
                e = $random(seed);
                chan_req[c] <= '{k != 3 && k != 5, e[1:0]};
                if (k < 3) p = p + stp(e[1:0]);
            end
            @(negedge core_clk);
            chk(chan_out[c].addr, p, "pointer");
            chk(chan_out[c].active, 1'h0, "active");
            chk(irq[u], 1'h1, "irq end");
            rd(ua(u, o + 14'h4), 32'h0, "count");
            rd(ua(u, PRF_OFF_IMASK), 32'h1 << c % 2, "mask");
            wr(ua(u, PRF_OFF_IDIS), 32'h1 << c % 2, 32'hFF);
            rd(ua(u, PRF_OFF_STAT), {func_status[u], 2'h3}, "end bit");
            chk(irq[u], 1'h0, "irq off");
        end
        wrap_up();
    end
endmodule : prf_frame_tb
bind prf_frame prf_frame_props u_props (.core_clk, .sys_rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .ic_win_sel, .cfg_out,
    .func_enable, .cmd_pulse, .chan_req, .chan_out);
